// ===== rtl/mode_ctrl_consts.svh
// constants for the cpu operating mode controller
`ifndef MODE_CTRL_CONSTS_SVH
`define MODE_CTRL_CONSTS_SVH
`define RESET_VECTOR_HI 16'hfffe
`define RESET_VECTOR_LO 16'hffff
`define STAT_OK 2'h0
`define STAT_LOW_POWER_ERR 2'h1
`define STAT_REFUSED 2'h2
`endif

// ===== rtl/mode_ctrl_pkg.sv
// types for the cpu operating mode controller
package mode_ctrl_pkg;
	typedef enum logic [2:0] {
		CMD_MEM_ACCESS = 3'h0,
		CMD_MEM_STATUS = 3'h1,
		CMD_DBG_REG = 3'h2,
		CMD_HALT_REQ = 3'h3,
		CMD_CPU_REG = 3'h4,
		CMD_TRACE = 3'h5,
		CMD_RESUME = 3'h6,
		CMD_NONE = 3'h7
	} dbg_cmd_t;
	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_RUN = 5'h02,
		ST_HALTED = 5'h04,
		ST_WAIT = 5'h08,
		ST_STOP = 5'h10
	} cpu_mode_t;
	typedef struct packed {
		logic valid;
		dbg_cmd_t cmd;
	} dbg_req_t;
	typedef struct packed {
		logic valid;
		logic [1:0] status;
		logic execute;
	} dbg_rsp_t;
	typedef struct packed {
		logic break_instr;
		logic wait_instr;
		logic stop_instr;
	} cpu_evt_t;
endpackage : mode_ctrl_pkg

// ===== rtl/cpu_operating_mode_control.sv
// cpu operating mode control: run, halted debug, wait and stop
// Behaviour
// - reset released with mode-select pin high enters run mode
// - run after reset fetches first address from two-byte top vector
// - reset released with mode-select pin low enters halted debug mode
// - halt request command from debug host enters halted debug mode
// - software break instruction enters halted debug mode
// - debug controller or trigger module breakpoint enters halted debug mode
// - halted mode stops fetching and waits for debug commands
// - non-intrusive commands accepted in run and halted modes
// - cpu register and trace commands execute only while halted
// - resume command while halted returns to user program
// - wait instruction stops the core clock
// - entering wait clears the interrupt mask bit
// - an interrupt in wait wakes core into interrupt stacking unless a halt request comes in the same cycle
// - in wait only halt request and memory-with-status accepted
// - memory-with-status in wait or stop reports low-power error, no access
// - halt request in wait wakes core straight into halted mode
// - peripheral clocks keep running in wait
// - stop halts core and bus clocks
// - stop instruction with stop enable clear causes illegal-opcode reset
`include "mode_ctrl_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cpu_operating_mode_control
	import mode_ctrl_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// pins and core events
	input wire logic DEBUG_MODE_SELECT_PIN,
	input wire cpu_evt_t CPU_EVT,
	input wire logic DBC_BREAKPOINT,
	input wire logic TRIGGER_BREAKPOINT,
	input wire logic IRQ_REQ,
	input wire logic STOP_ENABLE_BIT,
	input wire logic STOP_WAKE,
	// serial debug controller command path
	input wire dbg_req_t DBG_REQ,
	output var dbg_rsp_t DBG_RSP,
	// core control
	output var cpu_mode_t MODE,
	output logic FETCH_EN,
	output logic VECTOR_FETCH,
	output logic [15:0] VECTOR_ADDR,
	output logic CLEAR_IRQ_MASK,
	output logic START_STACKING,
	output logic CORE_CLK_EN,
	output logic BUS_CLK_EN,
	output logic PERIPH_CLK_EN,
	output logic ILLEGAL_OPCODE_RESET
);
	logic pin_meta;
	logic pin_sync;
	logic reset_seen;
	cpu_mode_t mode;
	cpu_mode_t next_mode;
	logic halt_cmd;
	logic resume_cmd;
	logic bp_hit;

	// two-stage synchroniser; only the second stage is read
	always_ff @(posedge CLK)
	begin
		pin_meta <= DEBUG_MODE_SELECT_PIN;
		pin_sync <= pin_meta;
	end

	assign halt_cmd = DBG_REQ.valid && DBG_REQ.cmd == CMD_HALT_REQ;
	assign resume_cmd = DBG_REQ.valid && DBG_REQ.cmd == CMD_RESUME;
	assign bp_hit = CPU_EVT.break_instr || DBC_BREAKPOINT || TRIGGER_BREAKPOINT;

	// mode transitions; ST_RESET lasts one cycle after release so pin is sampled once
	always_comb
	begin
		next_mode = mode;
		case (mode)
			ST_RESET:
				next_mode = pin_sync ? ST_RUN : ST_HALTED;
			ST_RUN:
			begin
				if (halt_cmd || bp_hit)
					next_mode = ST_HALTED;
				else if (CPU_EVT.wait_instr)
					next_mode = ST_WAIT;
				else if (CPU_EVT.stop_instr && STOP_ENABLE_BIT)
					next_mode = ST_STOP;
				else if (CPU_EVT.stop_instr)
					next_mode = ST_RESET;
			end
			ST_HALTED:
				if (resume_cmd)
					next_mode = ST_RUN;
			ST_WAIT:
			begin
				if (halt_cmd)
					next_mode = ST_HALTED;
				else if (IRQ_REQ)
					next_mode = ST_RUN;
			end
			ST_STOP:
			begin
				if (halt_cmd)
					next_mode = ST_HALTED;
				else if (STOP_WAKE || IRQ_REQ)
					next_mode = ST_RUN;
			end
			default:
				next_mode = ST_RESET;
		endcase
	end

	// mode register
	always_ff @(posedge CLK)
	begin
		if (SRST)
			mode <= ST_RESET;
		else
			mode <= next_mode;
	end

	// high during the first vector cycle; selects the low byte for the second
	// a later illegal-stop reset goes through the same path and refetches the vector
	always_ff @(posedge CLK)
	begin
		if (SRST)
			reset_seen <= 1'b0;
		else
			reset_seen <= (mode == ST_RESET) && pin_sync;
	end

	// vector fetch and core strobes
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			VECTOR_FETCH <= 1'b0;
			VECTOR_ADDR <= 16'h0000;
			CLEAR_IRQ_MASK <= 1'b0;
			START_STACKING <= 1'b0;
			ILLEGAL_OPCODE_RESET <= 1'b0;
		end
		else
		begin
			// high byte first, then low byte at the next address
			// two fetch cycles so the core sees both halves of the start address
			VECTOR_FETCH <= ((mode == ST_RESET) && pin_sync) || reset_seen;
			// address rests on the high byte outside the fetch
			VECTOR_ADDR <= reset_seen ? `RESET_VECTOR_LO : `RESET_VECTOR_HI;
			CLEAR_IRQ_MASK <= (mode == ST_RUN) && (next_mode == ST_WAIT);
			START_STACKING <= (mode == ST_WAIT) && (next_mode == ST_RUN);
			ILLEGAL_OPCODE_RESET <= (mode == ST_RUN) && CPU_EVT.stop_instr
				&& !STOP_ENABLE_BIT && !halt_cmd && !bp_hit && !CPU_EVT.wait_instr;
		end
	end

	// clock gating per mode; registered so outputs come from flops
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			MODE <= ST_RESET;
			FETCH_EN <= 1'b0;
			CORE_CLK_EN <= 1'b1;
			BUS_CLK_EN <= 1'b1;
			PERIPH_CLK_EN <= 1'b1;
		end
		else
		begin
			MODE <= next_mode;
			FETCH_EN <= (next_mode == ST_RUN);
			CORE_CLK_EN <= !(next_mode == ST_WAIT || next_mode == ST_STOP);
			BUS_CLK_EN <= (next_mode != ST_STOP);
			PERIPH_CLK_EN <= (next_mode != ST_STOP);
		end
	end

	// command acceptance; answers one cycle after the request
	always_ff @(posedge CLK)
	begin
		if (SRST)
			DBG_RSP <= '0;
		else
		begin
			DBG_RSP.valid <= DBG_REQ.valid;
			DBG_RSP.execute <= 1'b0;
			DBG_RSP.status <= `STAT_OK;
			if (DBG_REQ.valid)
			begin
				case (mode)
					ST_RUN:
						case (DBG_REQ.cmd)
							CMD_MEM_ACCESS, CMD_MEM_STATUS, CMD_DBG_REG, CMD_HALT_REQ:
								DBG_RSP.execute <= 1'b1;
							default:
								DBG_RSP.status <= `STAT_REFUSED;
						endcase
					ST_HALTED:
						DBG_RSP.execute <= (DBG_REQ.cmd != CMD_NONE);
					ST_WAIT, ST_STOP:
						case (DBG_REQ.cmd)
							CMD_MEM_STATUS:
								DBG_RSP.status <= `STAT_LOW_POWER_ERR;
							CMD_HALT_REQ:
								DBG_RSP.execute <= 1'b1;
							default:
								DBG_RSP.status <= `STAT_REFUSED;
						endcase
					default:
						DBG_RSP.status <= `STAT_REFUSED;
				endcase
			end
		end
	end

	// checks
	chk_pin_high_run: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RESET && pin_sync |=> mode == ST_RUN && VECTOR_FETCH)
		else $error("run not entered with pin high");
	chk_pin_low_halt: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RESET && !pin_sync |=> mode == ST_HALTED && !FETCH_EN)
		else $error("halt not entered with pin low");
	chk_break_halts: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && bp_hit |=> MODE == ST_HALTED)
		else $error("breakpoint did not halt");
	chk_trace_refused: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && DBG_REQ.valid && DBG_REQ.cmd == CMD_TRACE |=> !DBG_RSP.execute)
		else $error("trace executed in run");
	chk_resume_runs: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_HALTED && resume_cmd |=> FETCH_EN)
		else $error("resume ignored");
	chk_wait_mask: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && next_mode == ST_WAIT |=> CLEAR_IRQ_MASK && !CORE_CLK_EN && PERIPH_CLK_EN)
		else $error("wait entry wrong");
	chk_wait_status: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_WAIT && DBG_REQ.valid && DBG_REQ.cmd == CMD_MEM_STATUS
		|=> DBG_RSP.status == `STAT_LOW_POWER_ERR && !DBG_RSP.execute)
		else $error("status error missing");
	chk_wait_halt: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_WAIT && halt_cmd |=> mode == ST_HALTED && CORE_CLK_EN)
		else $error("halt in wait ignored");
	chk_stop_clocks: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_STOP |-> !BUS_CLK_EN && !CORE_CLK_EN)
		else $error("clocks running in stop");
	chk_stop_illegal: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && CPU_EVT.stop_instr && !STOP_ENABLE_BIT && !halt_cmd && !bp_hit
		&& !CPU_EVT.wait_instr |=> ILLEGAL_OPCODE_RESET && mode == ST_RESET)
		else $error("illegal stop not reset");
	cov_wait_irq: cover property (@(posedge CLK) mode == ST_WAIT && IRQ_REQ && !halt_cmd);
	cov_halt_resume: cover property (@(posedge CLK) mode == ST_HALTED && resume_cmd);
	cov_stop_enter: cover property (@(posedge CLK) mode == ST_RUN && next_mode == ST_STOP);
	cov_illegal_stop: cover property (@(posedge CLK) ILLEGAL_OPCODE_RESET);
	cov_pin_low_boot: cover property (@(posedge CLK) mode == ST_RESET && !pin_sync);

	// further checks, one per rule the controller owns

	// start address high byte comes first
	chk_vector_hi: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RESET && pin_sync |=> VECTOR_FETCH && VECTOR_ADDR == `RESET_VECTOR_HI)
		else $error("vector high byte missing");

	// low byte follows on the next cycle
	chk_vector_lo: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RESET && pin_sync |=> ##1 VECTOR_FETCH && VECTOR_ADDR == `RESET_VECTOR_LO)
		else $error("vector low byte missing");

	// host halt request stops the program in run
	chk_halt_cmd_run: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && halt_cmd |=> MODE == ST_HALTED)
		else $error("halt request ignored in run");

	// either breakpoint source alone is enough
	chk_dbg_break: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && (DBC_BREAKPOINT || TRIGGER_BREAKPOINT) |=> mode == ST_HALTED)
		else $error("debug breakpoint did not halt");

	// no user fetch while suspended
	chk_halted_no_fetch: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_HALTED && !resume_cmd |=> !FETCH_EN)
		else $error("fetch while halted");

	// non-intrusive commands run alongside the program
	chk_run_accepts: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && DBG_REQ.valid
		&& DBG_REQ.cmd inside {CMD_MEM_ACCESS, CMD_MEM_STATUS, CMD_DBG_REG, CMD_HALT_REQ}
		|=> DBG_RSP.valid && DBG_RSP.execute)
		else $error("non-intrusive command refused in run");

	// every request gets exactly one answer a cycle later
	chk_rsp_follows: assert property (@(posedge CLK) disable iff (SRST)
		DBG_RSP.valid == $past(DBG_REQ.valid) || $past(SRST))
		else $error("answer does not follow request");

	// cpu register access needs a halted core
	chk_cpu_reg_refused: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && DBG_REQ.valid && DBG_REQ.cmd == CMD_CPU_REG
		|=> DBG_RSP.status == `STAT_REFUSED && !DBG_RSP.execute)
		else $error("cpu register access in run");

	// trace, refused in run, is carried out once halted
	chk_halted_exec: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_HALTED && DBG_REQ.valid && DBG_REQ.cmd == CMD_TRACE |=> DBG_RSP.execute)
		else $error("trace refused while halted");

	// core unclocked for the whole wait
	chk_wait_core_off: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_WAIT |-> !CORE_CLK_EN)
		else $error("core clocked in wait");

	// interrupt wake goes straight into stacking
	chk_irq_wakes: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_WAIT && IRQ_REQ && !halt_cmd |=> START_STACKING && mode == ST_RUN)
		else $error("interrupt did not wake");

	// everything but halt and status is refused in wait
	chk_wait_refuse: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_WAIT && DBG_REQ.valid && !(DBG_REQ.cmd inside {CMD_MEM_STATUS, CMD_HALT_REQ})
		|=> !DBG_RSP.execute)
		else $error("command executed in wait");

	// stop gives the same status answer as wait
	chk_stop_status: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_STOP && DBG_REQ.valid && DBG_REQ.cmd == CMD_MEM_STATUS
		|=> DBG_RSP.status == `STAT_LOW_POWER_ERR && !DBG_RSP.execute)
		else $error("status error missing in stop");

	// peripherals and bus keep running in wait
	chk_wait_periph: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_WAIT |-> PERIPH_CLK_EN && BUS_CLK_EN)
		else $error("peripheral clock off in wait");

	// enabled stop really stops
	chk_stop_enter: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RUN && CPU_EVT.stop_instr && STOP_ENABLE_BIT && !halt_cmd && !bp_hit
		&& !CPU_EVT.wait_instr |=> mode == ST_STOP)
		else $error("enabled stop not entered");

	// reset state is one cycle, so the pin is read once
	chk_pin_once: assert property (@(posedge CLK) disable iff (SRST)
		mode == ST_RESET |=> mode != ST_RESET)
		else $error("reset state held too long");
endmodule : cpu_operating_mode_control
`default_nettype wire

// ===== testbench/debug_host_model.sv
// serial debug host model on the far side of the command path
`timescale 1ns/10ps
`default_nettype none
module debug_host_model
	import mode_ctrl_pkg::*;
(
	// clock
	input wire logic CLK,
	// command path into the device
	output var dbg_req_t DBG_REQ
);
	// idle shows no opcode so a stale command is never taken twice
	initial DBG_REQ = '{1'b0, CMD_NONE};

	// one-cycle strobe, raised and dropped on falling edges
	task automatic send(input dbg_cmd_t c);
		@(negedge CLK);
		DBG_REQ = '{1'b1, c};
		@(negedge CLK);
		DBG_REQ = '{1'b0, CMD_NONE};
	endtask : send
endmodule : debug_host_model
`default_nettype wire

// ===== testbench/cpu_operating_mode_control_bench.sv
// self-checking bench for the cpu operating mode controller
`include "mode_ctrl_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cpu_operating_mode_control_bench
	import mode_ctrl_pkg::*;
;
	logic clk = 0, srst = 1, pin = 1, dbc_bp = 0, trg_bp = 0, irq = 0, stop_en = 1;
	cpu_evt_t evt = '0;
	dbg_req_t req;
	dbg_rsp_t rsp;
	cpu_mode_t mode;
	logic fetch_en, vec_fetch, clr_mask, stacking, core_en, bus_en, periph_en, illegal;
	logic [15:0] vec_addr;
	int n_mismatch = 0;
	int total_checks = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	cpu_operating_mode_control dut_u (
		.CLK(clk), .SRST(srst), .DEBUG_MODE_SELECT_PIN(pin), .CPU_EVT(evt),
		.DBC_BREAKPOINT(dbc_bp), .TRIGGER_BREAKPOINT(trg_bp), .IRQ_REQ(irq),
		.STOP_ENABLE_BIT(stop_en), .STOP_WAKE(1'b0), .DBG_REQ(req), .DBG_RSP(rsp),
		.MODE(mode), .FETCH_EN(fetch_en), .VECTOR_FETCH(vec_fetch), .VECTOR_ADDR(vec_addr),
		.CLEAR_IRQ_MASK(clr_mask), .START_STACKING(stacking), .CORE_CLK_EN(core_en),
		.BUS_CLK_EN(bus_en), .PERIPH_CLK_EN(periph_en), .ILLEGAL_OPCODE_RESET(illegal)
	);
	debug_host_model host_u (.CLK(clk), .DBG_REQ(req));

	// verdict, also reached when a bounded wait runs out
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic fail(input string m);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, m);
	endtask : fail

	task automatic chk_mode(input cpu_mode_t e);
		total_checks++;
		if (mode !== e)
			fail("mode");
	endtask : chk_mode

	task automatic chk_sig(input logic [15:0] g, input logic [15:0] e, input string m);
		total_checks++;
		if (g !== e)
			fail(m);
	endtask : chk_sig

	task automatic chk_rsp(input dbg_rsp_t e);
		total_checks++;
		if (rsp !== e)
			fail("response");
	endtask : chk_rsp

	// reply expected for a command taken in a given mode
	function automatic dbg_rsp_t exp_rsp(input cpu_mode_t m, input dbg_cmd_t c);
		if (m == ST_HALTED || (m == ST_RUN && c < CMD_CPU_REG) || c == CMD_HALT_REQ)
			return '{1'b1, `STAT_OK, 1'b1};
		if (c == CMD_MEM_STATUS)
			return '{1'b1, `STAT_LOW_POWER_ERR, 1'b0};
		return '{1'b1, `STAT_REFUSED, 1'b0};
	endfunction : exp_rsp

	// mode is sampled before the strobe, as the take edge sees it
	task automatic send_cmd(input dbg_cmd_t c);
		cpu_mode_t m;
		m = mode;
		host_u.send(c);
		chk_rsp(exp_rsp(m, c));
	endtask : send_cmd

	task automatic strobe(input cpu_evt_t e, input logic [1:0] bp);
		@(negedge clk);
		evt = e;
		{dbc_bp, trg_bp} = bp;
		@(negedge clk);
		evt = '0;
		{dbc_bp, trg_bp} = 2'h0;
	endtask : strobe

	task automatic do_reset(input logic p);
		pin = p;
		srst = 1;
		repeat (10) @(negedge clk);
		srst = 0;
		for (int i = 0; i < 4 && mode === ST_RESET; i++)
			@(negedge clk);
		if (mode === ST_RESET)
		begin
			fail("reset timeout");
			test_done();
		end
		chk_mode(p ? ST_RUN : ST_HALTED);
		for (int i = 0; i < 3 && p && vec_fetch !== 1'b1; i++)
			@(negedge clk);
		chk_sig(vec_fetch, p, "vector fetch");
		if (p)
		begin
			chk_sig(vec_addr, `RESET_VECTOR_HI, "vector");
			@(negedge clk);
			chk_sig(vec_fetch, 1, "vector fetch lo");
			chk_sig(vec_addr, `RESET_VECTOR_LO, "vector lo");
		end
		chk_sig(fetch_en, p, "fetch");
		$display("reset with pin %0d done", p);
	endtask : do_reset

	// wait or stop entry, then a status read and random traffic that must not execute
	task automatic low_power(input logic stop);
		dbg_cmd_t c;
		strobe(stop ? 3'h1 : 3'h2, 2'h0);
		chk_mode(stop ? ST_STOP : ST_WAIT);
		chk_sig({core_en, periph_en, bus_en}, stop ? 3'h0 : 3'h3, "clocks");
		if (!stop)
			chk_sig(clr_mask, 1, "mask");
		for (int i = 0; i < 5; i++)
		begin
			c = i == 0 ? CMD_MEM_STATUS : dbg_cmd_t'($urandom_range(6, 0));
			if (c == CMD_HALT_REQ)
				c = CMD_DBG_REG;
			send_cmd(c);
		end
		$display("low power %0d done", stop);
	endtask : low_power

	initial
	begin
		void'($urandom(32'hc1fd));
		do_reset(1'b1);
		for (int c = 0; c < 7; c++)
			if (c != 3)
				send_cmd(dbg_cmd_t'(c));
		chk_mode(ST_RUN);
		send_cmd(CMD_HALT_REQ);
		chk_mode(ST_HALTED);
		chk_sig(fetch_en, 0, "fetch halted");
		for (int c = 0; c < 6; c++)
			send_cmd(dbg_cmd_t'(c));
		send_cmd(CMD_RESUME);
		chk_mode(ST_RUN);
		for (int k = 0; k < 3; k++)
		begin
			strobe(k == 0 ? 3'h4 : 3'h0, 2'(k));
			chk_mode(ST_HALTED);
			send_cmd(CMD_RESUME);
		end
		$display("halt entries done");
		low_power(1'b0);
		@(negedge clk);
		irq = 1;
		@(negedge clk);
		irq = 0;
		chk_mode(ST_RUN);
		chk_sig(stacking, 1, "stacking");
		low_power(1'b0);
		send_cmd(CMD_HALT_REQ);
		chk_mode(ST_HALTED);
		send_cmd(CMD_RESUME);
		low_power(1'b1);
		send_cmd(CMD_HALT_REQ);
		chk_mode(ST_HALTED);
		send_cmd(CMD_RESUME);
		stop_en = 0;
		strobe(3'h1, 2'h0);
		chk_sig(illegal, 1, "illegal stop");
		chk_sig(mode == ST_STOP, 0, "stopped");
		do_reset(1'b0);
		test_done();
	end
endmodule : cpu_operating_mode_control_bench
`default_nettype wire
